// >>> core/zshf_pkg.sv
// shared constants for the zero-speed hold flag block
package zshf_pkg;
   localparam int ZSHF_AXES = 32;
   localparam logic [3:0] ZSHF_VAR_FULL = 4'h0;  // 32 axes
   localparam logic [3:0] ZSHF_VAR_MID = 4'h1;   // 16 axes
   localparam logic [3:0] ZSHF_VAR_SMALL = 4'h2; // 8 axes
   localparam int ZSHF_AXES_MID = 16;
   localparam int ZSHF_AXES_SMALL = 8;
   // data-register map, in word numbers
   localparam int ZSHF_MON_BASE = 0;
   localparam int ZSHF_MON_WORDS = 20;
   localparam int ZSHF_CHG_BASE = 640;
   localparam int ZSHF_CHG_WORDS = 2;
   localparam int ZSHF_CMD_BASE = 704;
   localparam int ZSHF_CMD_WORDS = 54;
   localparam int ZSHF_GAP_WORDS = 42;
   localparam int ZSHF_USER_BASE = ZSHF_CMD_BASE + ZSHF_CMD_WORDS + ZSHF_GAP_WORDS;
   // apb register byte offsets
   localparam logic [11:0] ZSHF_OFF_ZERO = 12'h000;
   localparam logic [11:0] ZSHF_OFF_LOOP = 12'h004;
   localparam logic [11:0] ZSHF_OFF_LCMD = 12'h008;
   localparam logic [11:0] ZSHF_OFF_VAR = 12'h00c;
   localparam logic [11:0] ZSHF_OFF_MAP = 12'h010;
   localparam logic [31:0] ZSHF_RST_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {ZSHF_AREA_MON, ZSHF_AREA_CHG, ZSHF_AREA_CMD, ZSHF_AREA_NONE}
      zshf_area_t;
endpackage

// >>> core/zshf_axis_if.sv
// per-axis event bundle between the top and the flag engine
`timescale 1ns/1ns
`default_nettype none
interface zshf_axis_if #(parameter int AXES = 32);
   logic [AXES-1:0] zero_req;
   logic [AXES-1:0] spd_req;
   logic [AXES-1:0] stop_cause;
   logic [AXES-1:0] stop_done;
   logic [AXES-1:0] started;
   logic [AXES-1:0] inhibit;
   logic [AXES-1:0] follow_decel;
   logic [AXES-1:0] flag;
   modport src (output zero_req, spd_req, stop_cause, stop_done, started, inhibit,
      follow_decel, input flag);
   modport eng (input zero_req, spd_req, stop_cause, stop_done, started, inhibit,
      follow_decel, output flag);
endinterface
`default_nettype wire

// >>> core/zshf_engine.sv
// zero-speed accept flag engine, one flag per axis
`timescale 1ns/1ns
`default_nettype none
module zshf_engine #(
   parameter int AXES = 32
) (
   input wire logic clk,
   input wire logic reset,
   zshf_axis_if.eng ax
);
   import zshf_pkg::*;
   logic [AXES-1:0] flag_reg;
   logic [AXES-1:0] flag_next;
   logic [AXES-1:0] accept;

   // accept only while started and either no blocking deceleration or a follow-up deceleration is under way
   always_comb begin
      accept = ax.zero_req & ax.started & (~ax.inhibit | ax.follow_decel); // [RULE_04] [RULE_07] [RULE_08]
      flag_next = flag_reg;
      // clears first so that a same-cycle accept wins over every clear except a stop cause
      flag_next = flag_next & ~(ax.spd_req & ~ax.zero_req); // [RULE_05] [RULE_01]
      flag_next = flag_next & ~ax.stop_cause; // [RULE_06]
      flag_next = flag_next & ~ax.stop_done; // [RULE_01]
      flag_next = flag_next | (accept & ~ax.stop_cause); // [RULE_01]
   end

   // flag holds while stopped as long as start-accept stays on
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next & ax.started; // [RULE_02]
      end
   end

   assign ax.flag = flag_reg;

   chk_stop_clears_flag: assert property (@(posedge clk) disable iff (reset) // [RULE_06]
      (ax.stop_cause != '0) |=> ((flag_reg & $past(ax.stop_cause)) == '0))
      else $error("flag stayed on after stop cause");
   chk_inhibit_blocks_set: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
      ((ax.zero_req & ax.inhibit & ~ax.follow_decel & ~flag_reg) != '0) |=>
      ((flag_reg & $past(ax.zero_req & ax.inhibit & ~ax.follow_decel & ~flag_reg)) == '0))
      else $error("inhibited zero request was accepted");
   chk_follow_sets_flag: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
      ((ax.zero_req & ax.follow_decel & ax.started & ~ax.stop_cause) != '0) |=>
      ((flag_reg & $past(ax.zero_req & ax.follow_decel & ax.started & ~ax.stop_cause))
      == $past(ax.zero_req & ax.follow_decel & ax.started & ~ax.stop_cause)))
      else $error("follow-up zero request not accepted");
   chk_flag_needs_start: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
      ((flag_reg & ~$past(ax.started)) == '0))
      else $error("flag on without start accept");
endmodule
`default_nettype wire

// >>> core/zshf_top.sv
// zero-speed hold and loop-mode status block with apb registers
// What this block does
// RULE_01 - set flag on accepted zero/negative speed change; clear on speed change, stop
// RULE_02 - flag stays on while stopped if start-accept remains on
// RULE_03 - interpolation sets flags of all participating axes
// RULE_04 - zero request ignored after jog-release, handwheel, auto-decel, stop-cause decel
// RULE_05 - new speed change while decelerating to hold clears flag
// RULE_06 - any stop cause after acceptance clears flag
// RULE_07 - zero request after normal auto deceleration keeps flag off
// RULE_08 - zero request after follow-up auto deceleration start still sets flag
// RULE_09 - follow-up position change during hold does not restart motion
// RULE_10 - in virtual mode flag belongs to the virtual servo axis
// RULE_11 - loop-mode bit high for fully-closed, low for semi-closed loop
// RULE_12 - loop-change command switches amplifier; status reflects resulting mode
// RULE_13 - loop-mode bits one per axis, axis 1 lowest to axis 32
// RULE_14 - smaller variants treat only axes 1-16 or 1-8 as valid
// RULE_15 - twenty monitor words per axis for 32 axes from register zero
// RULE_16 - two control-change words per axis after the monitor area
// RULE_17 - fifty-four common command words then a forty-two word gap
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module zshf_top #(
   parameter int AXES = zshf_pkg::ZSHF_AXES
) (
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // per-axis motion events from the motion core
   input wire logic [AXES-1:0] zero_req,
   input wire logic [AXES-1:0] spd_req,
   input wire logic [AXES-1:0] interp_grp,
   input wire logic [AXES-1:0] stop_cause,
   input wire logic [AXES-1:0] stop_done,
   input wire logic [AXES-1:0] start_accept_flag,
   input wire logic [AXES-1:0] jog_release_decel,
   input wire logic [AXES-1:0] handwheel_active,
   input wire logic [AXES-1:0] auto_decel,
   input wire logic [AXES-1:0] stop_decel,
   input wire logic [AXES-1:0] follow_decel,
   input wire logic [AXES-1:0] follow_pos_chg,
   input wire logic virtual_mode,
   input wire logic [AXES-1:0] virt_zero_req,
   // amplifier loop mode, from the servo link (asynchronous)
   input wire logic [AXES-1:0] amp_full_closed,
   // outputs
   output logic [AXES-1:0] zero_speed_accept_flag,
   output logic [AXES-1:0] loop_mode_status,
   output logic [AXES-1:0] loop_change_cmd,
   output logic [AXES-1:0] restart_req,
   // data-register map lookup
   input wire logic [15:0] dreg_addr,
   output logic [1:0] dreg_area,
   output logic [4:0] dreg_axis
);
   import zshf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // mask of axes that this variant implements
   function automatic logic [AXES-1:0] valid_mask(input logic [3:0] v);
      logic [AXES-1:0] m;
      m = '0;
      for (int i = 0; i < AXES; i++) begin
         if (v == ZSHF_VAR_MID) begin
            m[i] = (i < ZSHF_AXES_MID);
         end else if (v == ZSHF_VAR_SMALL) begin
            m[i] = (i < ZSHF_AXES_SMALL);
         end else begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // widen a per-axis vector to a 32-bit bus word
   function automatic logic [31:0] to_word(input logic [AXES-1:0] v);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < AXES && i < 32; i++) begin
         w[i] = v[i];
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers and variant masking

   logic [3:0] variant_reg;
   logic [AXES-1:0] lcmd_reg;
   logic [AXES-1:0] vmask;
   logic [AXES-1:0] amp_s1_reg;
   logic [AXES-1:0] amp_s2_reg;
   logic [AXES-1:0] loop_reg;

   assign vmask = valid_mask(variant_reg); // [RULE_14]

   ////////////////////////////////////////////////////////////////////////////
   // zero-speed request shaping

   logic [AXES-1:0] eff_zero;
   logic [AXES-1:0] grp_hit;
   logic [AXES-1:0] src_zero;
   zshf_axis_if #(.AXES(AXES)) axb ();

   // virtual mode takes requests for the virtual servo axis
   assign src_zero = virtual_mode ? virt_zero_req : zero_req; // [RULE_10]
   // a request on any axis of an interpolation group reaches every valid member
   assign grp_hit = ((src_zero & interp_grp) != '0) ? interp_grp : '0; // [RULE_03]
   assign eff_zero = (src_zero | grp_hit) & vmask;

   assign axb.zero_req = eff_zero;
   assign axb.spd_req = spd_req & vmask;
   assign axb.stop_cause = stop_cause;
   assign axb.stop_done = stop_done;
   assign axb.started = start_accept_flag & vmask;
   // blocking decelerations; follow-up decel is the exception handled in the engine
   assign axb.inhibit = jog_release_decel | handwheel_active | auto_decel | stop_decel; // [RULE_04]
   assign axb.follow_decel = follow_decel & ~jog_release_decel & ~handwheel_active
      & ~stop_decel; // [RULE_08]

   zshf_engine #(.AXES(AXES)) u_engine (
      .clk(clk),
      .reset(reset),
      .ax(axb)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output flags and restart suppression

   // flag output is already a flop inside the engine; re-registered here for clean timing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         zero_speed_accept_flag <= '0;
      end else begin
         zero_speed_accept_flag <= axb.flag; // [RULE_01]
      end
   end

   // a position change restarts only axes not held at zero speed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         restart_req <= '0;
      end else begin
         restart_req <= follow_pos_chg & ~axb.flag & vmask; // [RULE_09]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // loop mode: synchroniser, status and command

   // amplifier state comes from another domain, two flops before use
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         amp_s1_reg <= '0;
         amp_s2_reg <= '0;
      end else begin
         amp_s1_reg <= amp_full_closed;
         amp_s2_reg <= amp_s1_reg;
      end
   end

   // bit i is axis i+1, high means fully-closed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loop_reg <= '0;
         loop_mode_status <= '0;
      end else begin
         loop_reg <= amp_s2_reg & vmask; // [RULE_11] [RULE_13]
         loop_mode_status <= amp_s2_reg & vmask; // [RULE_12]
      end
   end

   // software's loop-change command drives the amplifiers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loop_change_cmd <= '0;
      end else begin
         loop_change_cmd <= lcmd_reg & vmask; // [RULE_12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data-register map lookup

   logic [1:0] area_next;
   logic [4:0] axis_next;
   int unsigned a;

   // classify a word number into its area and owning axis
   always_comb begin
      a = 32'(dreg_addr);
      area_next = ZSHF_AREA_NONE;
      axis_next = 5'h00;
      if (a < ZSHF_MON_BASE + ZSHF_MON_WORDS * ZSHF_AXES) begin
         area_next = ZSHF_AREA_MON; // [RULE_15]
         axis_next = 5'((a - ZSHF_MON_BASE) / ZSHF_MON_WORDS);
      end else if (a >= ZSHF_CHG_BASE && a < ZSHF_CHG_BASE + ZSHF_CHG_WORDS * ZSHF_AXES) begin
         area_next = ZSHF_AREA_CHG; // [RULE_16]
         axis_next = 5'((a - ZSHF_CHG_BASE) / ZSHF_CHG_WORDS);
      end else if (a >= ZSHF_CMD_BASE && a < ZSHF_CMD_BASE + ZSHF_CMD_WORDS) begin
         area_next = ZSHF_AREA_CMD; // [RULE_17]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dreg_area <= ZSHF_AREA_NONE;
         dreg_axis <= 5'h00;
      end else begin
         dreg_area <= area_next;
         dreg_axis <= axis_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, no wait states: ready in the access phase

   logic setup_ok;
   logic wr_hit;
   logic rd_hit;
   logic known;
   logic [31:0] rd_next;

   assign setup_ok = psel && !penable;
   assign wr_hit = psel && penable && pwrite && pready;
   assign rd_hit = psel && !penable && !pwrite;

   // read mux, unmapped reads as zero with an error
   always_comb begin
      known = 1'b1;
      rd_next = ZSHF_RST_WORD;
      unique case (paddr)
         ZSHF_OFF_ZERO: rd_next = to_word(axb.flag);
         ZSHF_OFF_LOOP: rd_next = to_word(loop_reg);
         ZSHF_OFF_LCMD: rd_next = to_word(lcmd_reg);
         ZSHF_OFF_VAR: rd_next = {28'h0000000, variant_reg};
         ZSHF_OFF_MAP: rd_next = 32'(ZSHF_USER_BASE);
         default: known = 1'b0;
      endcase
   end

   // ready rises for the access cycle and drops after it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= ZSHF_RST_WORD;
      end else begin
         pready <= setup_ok;
         pslverr <= setup_ok && !known;
         if (rd_hit) begin
            prdata <= rd_next;
         end
      end
   end

   // writable registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lcmd_reg <= '0;
         variant_reg <= ZSHF_VAR_FULL;
      end else if (wr_hit) begin
         if (paddr == ZSHF_OFF_LCMD) begin
            lcmd_reg <= pwdata[AXES-1:0]; // [RULE_12]
         end
         if (paddr == ZSHF_OFF_VAR) begin
            variant_reg <= pwdata[3:0]; // [RULE_14]
         end
      end
   end

   chk_loop_follows_amp: assert property (@(posedge clk) disable iff (reset) // [RULE_11]
      loop_mode_status == ($past(amp_s2_reg) & $past(vmask)))
      else $error("loop status does not follow amplifier");
   chk_variant_masks: assert property (@(posedge clk) disable iff (reset) // [RULE_14]
      (variant_reg == ZSHF_VAR_SMALL) |-> ((axb.flag & ~vmask) == '0 || $changed(variant_reg)
      || $changed($past(variant_reg))))
      else $error("flag set on invalid axis");
   chk_no_restart_held: assert property (@(posedge clk) disable iff (reset) // [RULE_09]
      (restart_req & $past(axb.flag)) == '0)
      else $error("restart while zero-speed hold");
   chk_apb_ready_once: assert property (@(posedge clk) disable iff (reset)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready timing wrong");

   ////////////////////////////////////////////////////////////////////////////
   // map, masking, request shaping and command write checks

   // low word numbers always belong to the axis monitor area
   chk_map_monitor: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
      (32'(dreg_addr) < ZSHF_CHG_BASE) |=> (dreg_area == ZSHF_AREA_MON))
      else $error("monitor word not classed as monitor");

   // the first monitor block is owned by the first axis
   chk_map_first_axis: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
      (32'(dreg_addr) < ZSHF_MON_WORDS) |=> (dreg_axis == 5'h00))
      else $error("first monitor block not on first axis");

   // control-change words sit right after the monitor area
   chk_map_change: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
      (32'(dreg_addr) >= ZSHF_CHG_BASE && 32'(dreg_addr) < ZSHF_CMD_BASE) |=>
      (dreg_area == ZSHF_AREA_CHG))
      else $error("control-change word misclassed");

   // common command words follow the control-change area
   chk_map_command: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
      (32'(dreg_addr) >= ZSHF_CMD_BASE && 32'(dreg_addr) < ZSHF_CMD_BASE + ZSHF_CMD_WORDS)
      |=> (dreg_area == ZSHF_AREA_CMD))
      else $error("command word misclassed");

   // the unusable gap must never decode as a live area
   chk_map_gap: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
      (32'(dreg_addr) >= ZSHF_CMD_BASE + ZSHF_CMD_WORDS && 32'(dreg_addr) < ZSHF_USER_BASE)
      |=> (dreg_area == ZSHF_AREA_NONE))
      else $error("gap word decoded as live area");

   // in virtual mode a real-axis request alone must not reach the engine
   chk_virt_source: assert property (@(posedge clk) disable iff (reset) // [RULE_10]
      (virtual_mode && virt_zero_req == '0) |-> (eff_zero == '0))
      else $error("real request used in virtual mode");

   // one member's request reaches every valid member of the group
   chk_interp_spread: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
      ((src_zero & interp_grp) != '0) |-> ((eff_zero & interp_grp) == (interp_grp & vmask)))
      else $error("interpolation request not spread");

   // commands never reach axes that this variant lacks
   chk_cmd_masked: assert property (@(posedge clk) disable iff (reset) // [RULE_14]
      ((loop_change_cmd & ~$past(vmask)) == '0))
      else $error("loop command on invalid axis");

   // a completed write to the command register lands at once
   chk_lcmd_write: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
      (psel && penable && pwrite && pready && paddr == ZSHF_OFF_LCMD) |=>
      (lcmd_reg == $past(pwdata[AXES-1:0])))
      else $error("loop command write lost");
endmodule
`default_nettype wire

// >>> tb/zshf_amp_model.sv
// servo amplifier model: loop mode follows the loop-change command
`timescale 1ns/1ns
`default_nettype none
module zshf_amp_model #(
   parameter int AXES = 32,
   parameter int DLY = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [AXES-1:0] loop_change_cmd,
   output logic [AXES-1:0] amp_full_closed
);
   logic [AXES-1:0] pipe_reg [DLY];
   ////////////////////////////////////////////////////////////////////////////////
   // a drive needs a few cycles to switch its loop, so the bench never sees it instantly
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DLY; i++) pipe_reg[i] <= '0;
      end else begin
         pipe_reg[0] <= loop_change_cmd;
         for (int i = 1; i < DLY; i++) pipe_reg[i] <= pipe_reg[i-1];
      end
   end
   // high while fully closed, low while semi closed
   assign amp_full_closed = pipe_reg[DLY-1];
endmodule
`default_nettype wire

// >>> tb/test_zero_speed_hold_flags.sv
// self-checking bench for the zero-speed hold and loop-mode block
`timescale 1ns/1ns
`default_nettype none
module test_zero_speed_hold_flags;
   import zshf_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, err, virtual_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rs, zflag, lstat, lcmd, restart, amp;
   logic [31:0] zero_req, spd_req, interp_grp, stop_cause, start_accept_flag, follow_pos_chg;
   logic [31:0] jog_release_decel, handwheel_active, auto_decel, stop_decel, follow_decel;
   logic [31:0] virt_zero_req, stop_done;
   logic [15:0] dreg_addr;
   logic [1:0] dreg_area;
   logic [4:0] dreg_axis;
   int miscompares, num_checks;
   ////////////////////////////////////////////////////////////////////////////////
   zshf_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .zero_req(zero_req), .spd_req(spd_req), .interp_grp(interp_grp),
      .stop_cause(stop_cause), .stop_done(stop_done), .start_accept_flag(start_accept_flag),
      .jog_release_decel(jog_release_decel), .handwheel_active(handwheel_active),
      .auto_decel(auto_decel), .stop_decel(stop_decel), .follow_decel(follow_decel),
      .follow_pos_chg(follow_pos_chg), .virtual_mode(virtual_mode),
      .virt_zero_req(virt_zero_req), .amp_full_closed(amp), .zero_speed_accept_flag(zflag),
      .loop_mode_status(lstat), .loop_change_cmd(lcmd), .restart_req(restart),
      .dreg_addr(dreg_addr), .dreg_area(dreg_area), .dreg_axis(dreg_axis));
   zshf_amp_model amp_i (.clk(clk), .reset(reset), .loop_change_cmd(lcmd),
      .amp_full_closed(amp));
   // 100 mhz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // apb transfer; pready and read data are taken at the rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) begin
         miscompares++;
         give_verdict;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one-cycle event, restart sampled one edge on, flag three edges on
   task pulse(input int k, input logic [31:0] m);
      @(posedge clk);
      case (k)
         0: zero_req <= m;
         1: spd_req <= m;
         2: stop_cause <= m;
         3: virt_zero_req <= m;
         5: stop_done <= m;
         default: follow_pos_chg <= m;
      endcase
      @(posedge clk);
      {zero_req, spd_req, stop_cause, stop_done, virt_zero_req, follow_pos_chg} <= '0;
      #1 rs = restart;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task t_regs;
      apb(1'b0, ZSHF_OFF_ZERO, 32'h0);
      check("zero reg", rd, 32'h0);
      apb(1'b0, ZSHF_OFF_MAP, 32'h0);
      check("user base", rd, 32'd800);
      apb(1'b0, 12'h014, 32'h0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      $display("registers done");
   endtask
   task t_basic;
      @(posedge clk);
      start_accept_flag <= 32'h1;
      pulse(0, 32'h1);
      check("set", zflag, 32'h1);
      repeat (20) @(posedge clk);
      apb(1'b0, ZSHF_OFF_ZERO, 32'h0);
      check("hold", rd, 32'h1);
      pulse(4, 32'h1);
      check("no restart", rs, 32'h0);
      pulse(1, 32'h1);
      check("spd clear", zflag, 32'h0);
      pulse(4, 32'h1);
      check("restart", rs, 32'h1);
      pulse(0, 32'h1);
      pulse(2, 32'h1);
      check("stop clear", zflag, 32'h0);
      pulse(0, 32'h1);
      check("reset", zflag, 32'h1);
      pulse(5, 32'h1);
      check("done clear", zflag, 32'h0);
      $display("basic done");
   endtask
   // each decel or handwheel state in turn, then none
   task t_inhibit;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         jog_release_decel <= 32'(i == 0);
         handwheel_active <= 32'(i == 1);
         auto_decel <= 32'(i == 2);
         stop_decel <= 32'(i == 3);
         pulse(0, 32'h1);
         check("inhibit", zflag, 32'(i == 4));
         pulse(2, 32'h1);
      end
      @(posedge clk);
      auto_decel <= 32'h1;
      follow_decel <= 32'h1;
      pulse(0, 32'h1);
      check("follow", zflag, 32'h1);
      pulse(2, 32'h1);
      auto_decel <= 32'h0;
      follow_decel <= 32'h0;
      $display("inhibit done");
   endtask
   task t_interp_virt;
      @(posedge clk);
      interp_grp <= 32'h7;
      start_accept_flag <= 32'h7;
      pulse(0, 32'h2);
      check("interp", zflag, 32'h7);
      pulse(2, 32'h7);
      interp_grp <= 32'h0;
      virtual_mode <= 1'b1;
      pulse(0, 32'h1);
      check("virt real", zflag, 32'h0);
      pulse(3, 32'h1);
      check("virt set", zflag, 32'h1);
      pulse(2, 32'h1);
      virtual_mode <= 1'b0;
      $display("interp and virtual done");
   endtask
   task t_loop;
      logic [31:0] v [3] = '{32'h5, 32'h8000_0001, 32'h0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ZSHF_OFF_LCMD, v[i]);
         @(posedge clk);
         #1;
         check("lcmd", lcmd, v[i]);
         repeat (12) @(posedge clk);
         check("lstat", lstat, v[i]);
         apb(1'b0, ZSHF_OFF_LOOP, 32'h0);
         check("loop reg", rd, v[i]);
      end
      for (int i = 2; i >= 0; i--) begin
         apb(1'b1, ZSHF_OFF_VAR, 32'(i));
         apb(1'b1, ZSHF_OFF_LCMD, 32'hffff_ffff);
         @(posedge clk);
         #1;
         check("variant", lcmd, (i == 2) ? 32'hff : (i == 1) ? 32'hffff : '1);
      end
      apb(1'b1, ZSHF_OFF_LCMD, 32'h0);
      $display("loop done");
   endtask
   // boundaries of each register area
   task t_map;
      int a [8] = '{0, 639, 640, 703, 704, 757, 758, 800};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         dreg_addr <= 16'(a[i]);
         @(posedge clk);
         #1;
         check("area", 32'(dreg_area), 32'(i / 2));
         if (i < 4) check("axis", 32'(dreg_axis), (i % 2) ? 32'd31 : 32'd0);
      end
      $display("map done");
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      miscompares++;
      give_verdict;
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, virtual_mode, reset} = 5'h1;
      {paddr, pwdata, dreg_addr} = '0;
      {zero_req, spd_req, interp_grp, stop_cause, start_accept_flag, follow_pos_chg} = '0;
      {jog_release_decel, handwheel_active, auto_decel, stop_decel, follow_decel} = '0;
      virt_zero_req = '0;
      stop_done = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_basic;
      t_inhibit;
      t_interp_virt;
      t_loop;
      t_map;
      give_verdict;
   end
endmodule
`default_nettype wire
